//--- hw/reset_state_initializer.v
`timescale 1ns/100ps
`include "reset_state_initializer_defines.vh"

// Function
// - Keep time-out and power-down flags, updated by reset kind
// - Low-voltage reset in fast mode leaves both flags unchanged
// - Watchdog reset in fast mode sets time-out, keeps power-down
// - Watchdog reset in idle or sleep sets both flags
// - Power-on clears program counter and both flags
// - Interrupt control register cleared after fast-mode reset, event mask kept
// - Watchdog and time-base counters cleared, watchdog restarts counting
// - Timer control registers loaded with zero, except on sleep watchdog reset
// - Port data and direction registers loaded with all ones, except on sleep watchdog reset
// - Stack pointer to top of stack, low four bits cleared
// - Power-on loads watchdog, soft-reset and level-select defaults
// - Low-voltage reset keeps accumulator and level select, sets its flag
// - Fast-mode watchdog reset reloads level select, keeps reset cause flags
// - Sleep watchdog reset clears only PC low, stack low, pin-select nibble, receive count
// - Accumulator left uninitialised by power-on
// - Unimplemented bits hold no state
// - Receive count cleared at every reset kind
module reset_state_initializer #(
  parameter HOLD_CYC = `RST_HOLD_CYC,
  parameter NUM_TMR  = 6
) (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   srst,
  // Reset sources
  input  wire                   por_req,
  input  wire                   lvr_req,
  input  wire                   wdt_req,
  input  wire                   sleep_mode,
  // Register port
  input  wire [7:0]             reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // Core side
  output wire                   core_rst,
  output reg                    wdt_clear,
  output reg                    timebase_clear,
  output reg                    wdt_run,
  output reg                    watchdog_timeout_flag,
  output reg                    power_down_flag,
  output reg  [3:0]             reset_cause_flag_reg,
  output reg  [7:0]             watchdog_control_reg,
  output reg  [7:0]             software_reset_control_reg,
  output reg  [7:0]             low_voltage_level_select_reg,
  output reg  [7:0]             program_counter_low_byte,
  output reg  [7:0]             stack_pointer_reg,
  output reg  [2:0]             serial_receive_count_reg,
  output reg  [7:0]             accumulator_reg,
  output reg  [7:0]             port_a_data,
  output reg  [7:0]             port_a_dir,
  output reg  [7:0]             port_b_data,
  output reg  [7:0]             port_b_dir,
  output reg  [5:0]             port_c_data,
  output reg  [5:0]             port_c_dir,
  output reg  [7:0]             int_ctrl,
  output reg  [7:0]             pin_sel,
  output wire [8*NUM_TMR-1:0]   tmr_ctrl,
  // Interrupt
  output wire                   irq
);

  // ========================================================
  // Sequencer
  reg                 state_q;
  reg  [1:0]          cause_q;
  reg  [15:0]         hold_cnt_q;
  reg  [1:0]          req_cause;
  reg                 req_any;
  wire                release_w;
  wire                lvr_ok;

  // Low-voltage detection is off in idle or sleep
  assign lvr_ok    = lvr_req & ~sleep_mode;
  assign release_w = (state_q == `ST_HOLD) && (hold_cnt_q == 16'h0000) && !req_any;
  assign core_rst  = (state_q == `ST_HOLD);

  always @* begin
    req_any   = por_req | lvr_ok | wdt_req;
    req_cause = `CAUSE_POR;
    if (por_req) begin
      req_cause = `CAUSE_POR;
    end else if (lvr_ok) begin
      req_cause = `CAUSE_LVR;
    end else if (sleep_mode) begin
      req_cause = `CAUSE_WDT_SLEEP;
    end else begin
      req_cause = `CAUSE_WDT_FAST;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_q    <= `ST_RUN;
      cause_q    <= `CAUSE_POR;
      hold_cnt_q <= 16'h0000;
    end else if (req_any) begin
      state_q    <= `ST_HOLD;
      hold_cnt_q <= HOLD_CYC[15:0] - 16'h0001;
      if (state_q == `ST_RUN || req_cause < cause_q) begin
        cause_q <= req_cause;
      end
    end else begin
      case (state_q)
        `ST_HOLD: begin
          if (hold_cnt_q == 16'h0000) begin
            state_q <= `ST_RUN;
          end else begin
            hold_cnt_q <= hold_cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= `ST_RUN;
        end
      endcase
    end
  end

  // ========================================================
  // Counter clear strobes
  always @(posedge clk_sys) begin
    if (srst) begin
      wdt_clear      <= 1'b1;
      timebase_clear <= 1'b1;
      wdt_run        <= 1'b0;
    end else begin
      wdt_clear      <= core_rst;
      timebase_clear <= core_rst;
      wdt_run        <= !core_rst || release_w;
    end
  end

  // ========================================================
  // Register state
  reg  [7:0]          tmr_q [0:NUM_TMR-1];
  reg  [3:0]          evt_q;
  reg  [3:0]          mask_q;
  wire                full_reload;
  wire                wr_ok;
  integer             i;

  // Fast-mode causes reload most registers, sleep wake touches little
  assign full_reload = release_w && (cause_q != `CAUSE_WDT_SLEEP);
  assign wr_ok       = reg_wr && !release_w;

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g = g + 1) begin : g_tmr
      assign tmr_ctrl[8*g+7:8*g] = tmr_q[g];
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (srst) begin
      watchdog_timeout_flag        <= 1'b0;
      power_down_flag              <= 1'b0;
      reset_cause_flag_reg         <= `RV_RST_CAUSE;
      watchdog_control_reg         <= `RV_WDT_CTRL;
      software_reset_control_reg   <= `RV_SW_RST_CTRL;
      low_voltage_level_select_reg <= `RV_LV_SEL;
      program_counter_low_byte     <= `RV_ZERO8;
      stack_pointer_reg            <= `RV_ZERO8;
      serial_receive_count_reg     <= `RV_RX_COUNT;
      port_a_data                  <= `RV_ONES8;
      port_a_dir                   <= `RV_ONES8;
      port_b_data                  <= `RV_ONES8;
      port_b_dir                   <= `RV_ONES8;
      port_c_data                  <= `RV_ONES6;
      port_c_dir                   <= `RV_ONES6;
      int_ctrl                     <= `RV_ZERO8;
      pin_sel                      <= `RV_ZERO8;
      for (i = 0; i < NUM_TMR; i = i + 1) begin
        tmr_q[i] <= `RV_ZERO8;
      end
    end else if (release_w) begin
      // Common to every cause
      program_counter_low_byte <= `RV_ZERO8;
      stack_pointer_reg        <= stack_pointer_reg & ~`SP_LOW_MASK;
      serial_receive_count_reg <= `RV_RX_COUNT;
      pin_sel                  <= pin_sel & ~`PIN_SEL_HI_MASK;
      if (full_reload) begin
        watchdog_control_reg       <= `RV_WDT_CTRL;
        software_reset_control_reg <= `RV_SW_RST_CTRL;
        stack_pointer_reg          <= `RV_ZERO8;
        port_a_data                <= `RV_ONES8;
        port_a_dir                 <= `RV_ONES8;
        port_b_data                <= `RV_ONES8;
        port_b_dir                 <= `RV_ONES8;
        port_c_data                <= `RV_ONES6;
        port_c_dir                 <= `RV_ONES6;
        int_ctrl                   <= `RV_ZERO8;
        pin_sel                    <= `RV_ZERO8;
        for (i = 0; i < NUM_TMR; i = i + 1) begin
          tmr_q[i] <= `RV_ZERO8;
        end
      end
      case (cause_q)
        `CAUSE_POR: begin
          watchdog_timeout_flag        <= 1'b0;
          power_down_flag              <= 1'b0;
          reset_cause_flag_reg         <= `RV_RST_CAUSE;
          low_voltage_level_select_reg <= `RV_LV_SEL;
        end
        `CAUSE_LVR: begin
          reset_cause_flag_reg[`BIT_LOW_VOLTAGE_RESET_FLAG] <= 1'b1;
        end
        `CAUSE_WDT_FAST: begin
          watchdog_timeout_flag        <= 1'b1;
          low_voltage_level_select_reg <= `RV_LV_SEL;
        end
        default: begin
          watchdog_timeout_flag <= 1'b1;
          power_down_flag       <= 1'b1;
        end
      endcase
    end else if (wr_ok) begin
      case (reg_addr)
        `OFS_STATUS: begin
          watchdog_timeout_flag <= reg_wdata[`BIT_TO];
          power_down_flag       <= reg_wdata[`BIT_PDF];
        end
        `OFS_RST_CAUSE:   reset_cause_flag_reg         <= reg_wdata[3:0];
        `OFS_WDT_CTRL:    watchdog_control_reg         <= reg_wdata;
        `OFS_SW_RST_CTRL: software_reset_control_reg   <= reg_wdata;
        `OFS_LV_SEL:      low_voltage_level_select_reg <= reg_wdata;
        `OFS_PC_LOW:      program_counter_low_byte     <= reg_wdata;
        `OFS_STACK_PTR:   stack_pointer_reg            <= reg_wdata & `SP_IMPL_MASK;
        `OFS_RX_COUNT:    serial_receive_count_reg     <= reg_wdata[2:0];
        `OFS_PORT_A:      port_a_data                  <= reg_wdata;
        `OFS_PORT_A_DIR:  port_a_dir                   <= reg_wdata;
        `OFS_PORT_B:      port_b_data                  <= reg_wdata;
        `OFS_PORT_B_DIR:  port_b_dir                   <= reg_wdata;
        `OFS_PORT_C:      port_c_data                  <= reg_wdata[5:0];
        `OFS_PORT_C_DIR:  port_c_dir                   <= reg_wdata[5:0];
        `OFS_INT_CTRL:    int_ctrl                     <= reg_wdata;
        `OFS_PIN_SEL:     pin_sel                      <= reg_wdata;
        default: begin
          for (i = 0; i < NUM_TMR; i = i + 1) begin
            if (reg_addr == `OFS_TMR_BASE + i[7:0]) begin
              tmr_q[i] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  // ========================================================
  // Accumulator, kept through every reset kind
  always @(posedge clk_sys) begin
    if (wr_ok && reg_addr == `OFS_ACCUM) begin
      accumulator_reg <= reg_wdata;
    end
  end

  // ========================================================
  // Events and interrupt
  reg  [3:0]          evt_set;

  always @* begin
    evt_set = 4'h0;
    if (release_w) begin
      evt_set[cause_q] = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      evt_q  <= 4'h0;
      mask_q <= 4'h0;
    end else begin
      // Set wins over a clear in the same cycle
      if (reg_wr && reg_addr == `OFS_EVT_STATUS) begin
        evt_q <= (evt_q & ~reg_wdata[3:0]) | evt_set;
      end else begin
        evt_q <= evt_q | evt_set;
      end
      if (reg_wr && reg_addr == `OFS_EVT_MASK) begin
        mask_q <= reg_wdata[3:0];
      end
    end
  end

  assign irq = |(evt_q & mask_q);

  // ========================================================
  // Read port
  reg  [7:0]          rd_mux;
  // Own loop index, the clocked process keeps its own
  integer             j;

  always @* begin
    rd_mux = `RV_ZERO8;
    case (reg_addr)
      `OFS_STATUS: begin
        rd_mux[`BIT_TO]  = watchdog_timeout_flag;
        rd_mux[`BIT_PDF] = power_down_flag;
      end
      `OFS_RST_CAUSE:   rd_mux = {4'h0, reset_cause_flag_reg};
      `OFS_WDT_CTRL:    rd_mux = watchdog_control_reg;
      `OFS_SW_RST_CTRL: rd_mux = software_reset_control_reg;
      `OFS_LV_SEL:      rd_mux = low_voltage_level_select_reg;
      `OFS_PC_LOW:      rd_mux = program_counter_low_byte;
      `OFS_STACK_PTR:   rd_mux = stack_pointer_reg;
      `OFS_RX_COUNT:    rd_mux = {5'h00, serial_receive_count_reg};
      `OFS_PORT_A:      rd_mux = port_a_data;
      `OFS_PORT_A_DIR:  rd_mux = port_a_dir;
      `OFS_PORT_B:      rd_mux = port_b_data;
      `OFS_PORT_B_DIR:  rd_mux = port_b_dir;
      `OFS_PORT_C:      rd_mux = {2'h0, port_c_data};
      `OFS_PORT_C_DIR:  rd_mux = {2'h0, port_c_dir};
      `OFS_INT_CTRL:    rd_mux = int_ctrl;
      `OFS_PIN_SEL:     rd_mux = pin_sel;
      `OFS_ACCUM:       rd_mux = accumulator_reg;
      `OFS_EVT_STATUS:  rd_mux = {4'h0, evt_q};
      `OFS_EVT_MASK:    rd_mux = {4'h0, mask_q};
      `OFS_SEQ_STATE:   rd_mux = {4'h0, 1'b0, cause_q, state_q};
      default: begin
        for (j = 0; j < NUM_TMR; j = j + 1) begin
          if (reg_addr == `OFS_TMR_BASE + j[7:0]) begin
            rd_mux = tmr_q[j];
          end
        end
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= `RV_ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= `RV_ZERO8;
    end
  end

endmodule // reset_state_initializer

//--- include/reset_state_initializer_defines.vh
`ifndef RESET_STATE_INITIALIZER_DEFINES_VH
`define RESET_STATE_INITIALIZER_DEFINES_VH

// ==========================================================
// Timing
`define CLK_MHZ              50
`define RST_HOLD_NS          100
`define RST_HOLD_CYC         ((`RST_HOLD_NS * `CLK_MHZ + 999) / 1000)

// ==========================================================
// Reset causes, lower code wins
`define CAUSE_POR            2'h0
`define CAUSE_LVR            2'h1
`define CAUSE_WDT_FAST       2'h2
`define CAUSE_WDT_SLEEP      2'h3

// ==========================================================
// Sequencer states
`define ST_RUN               1'b0
`define ST_HOLD              1'b1

// ==========================================================
// Register offsets
`define OFS_STATUS           8'h00
`define OFS_RST_CAUSE        8'h01
`define OFS_WDT_CTRL         8'h02
`define OFS_SW_RST_CTRL      8'h03
`define OFS_LV_SEL           8'h04
`define OFS_PC_LOW           8'h05
`define OFS_STACK_PTR        8'h06
`define OFS_RX_COUNT         8'h07
`define OFS_PORT_A           8'h08
`define OFS_PORT_A_DIR       8'h09
`define OFS_PORT_B           8'h0A
`define OFS_PORT_B_DIR       8'h0B
`define OFS_PORT_C           8'h0C
`define OFS_PORT_C_DIR       8'h0D
`define OFS_INT_CTRL         8'h0E
`define OFS_PIN_SEL          8'h0F
`define OFS_ACCUM            8'h10
`define OFS_EVT_STATUS       8'h11
`define OFS_EVT_MASK         8'h12
`define OFS_SEQ_STATE        8'h13
`define OFS_TMR_BASE         8'h18

// ==========================================================
// Field positions
`define BIT_TO               5
`define BIT_PDF              4
`define BIT_LOW_VOLTAGE_RESET_FLAG             2
`define SP_TOP_BIT           7

// ==========================================================
// Reset values
`define RV_ZERO8             8'h00
`define RV_ONES8             8'hFF
`define RV_ONES6             6'h3F
`define RV_WDT_CTRL          8'h53
`define RV_SW_RST_CTRL       8'h55
`define RV_LV_SEL            8'h55
`define RV_RX_COUNT          3'h0
`define RV_RST_CAUSE         4'h0
`define SP_LOW_MASK          8'h0F
`define SP_IMPL_MASK         8'h8F
`define PIN_SEL_HI_MASK      8'hF0

`endif

//--- bench/reset_state_initializer_checker.sv
`timescale 1ns/100ps
module reset_state_initializer_checker #(
  parameter HOLD_CYC = 5
) (
  // Clock and reset
  input wire       clk_sys,
  input wire       srst,
  // Reset sources
  input wire       por_req,
  input wire       lvr_req,
  input wire       wdt_req,
  input wire       sleep_mode,
  // Core side
  input wire       core_rst,
  input wire       wdt_clear,
  input wire       timebase_clear,
  input wire       wdt_run,
  input wire       watchdog_timeout_flag,
  input wire       power_down_flag,
  input wire [3:0] reset_cause_flag_reg,
  input wire [7:0] low_voltage_level_select_reg,
  input wire [7:0] program_counter_low_byte,
  input wire [7:0] stack_pointer_reg,
  input wire [2:0] serial_receive_count_reg,
  input wire [7:0] port_a_data,
  input wire [7:0] int_ctrl,
  input wire [7:0] pin_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ==========================================
  // Cause and pre-reset snapshot
  wire       lvr_ok = lvr_req & ~sleep_mode;
  wire       req    = por_req | lvr_ok | wdt_req;
  wire [1:0] code   = por_req ? 2'h0 : lvr_ok ? 2'h1 : sleep_mode ? 2'h3 : 2'h2;
  logic [1:0] cz_q, fl_q;
  logic [7:0] lv_q, pa_q;
  logic       act_q;
  int         cnt_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      act_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      cnt_q <= req ? 0 : (core_rst ? cnt_q + 1 : cnt_q);
      if (req && !core_rst) begin
        act_q <= 1'b1;
        cz_q  <= code;
        fl_q  <= {watchdog_timeout_flag, power_down_flag};
        lv_q  <= low_voltage_level_select_reg;
        pa_q  <= port_a_data;
      end else if (req && code < cz_q) begin
        cz_q <= code;
      end else if (!req && !core_rst) begin
        act_q <= 1'b0;
      end
    end
  end
  wire rel = core_rst == 1'b0 && act_q;
  // ==========================================
  // Properties
  property p_lvr_keep;
    $fell(core_rst) && cz_q == 2'h1 |-> {watchdog_timeout_flag, power_down_flag} == fl_q
      && low_voltage_level_select_reg == lv_q && reset_cause_flag_reg[2];
  endproperty
  a_lvr_keep: assert property (p_lvr_keep) else $error("lvr state");
  property p_wdt_fast;
    $fell(core_rst) && cz_q == 2'h2 |-> watchdog_timeout_flag && power_down_flag == fl_q[0]
      && low_voltage_level_select_reg == 8'h55;
  endproperty
  a_wdt_fast: assert property (p_wdt_fast) else $error("wdt fast state");
  property p_wdt_sleep;
    $fell(core_rst) && cz_q == 2'h3 |-> watchdog_timeout_flag && power_down_flag
      && program_counter_low_byte == 8'h00 && stack_pointer_reg[3:0] == 4'h0
      && pin_sel[7:4] == 4'h0 && port_a_data == pa_q;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("wdt sleep state");
  property p_por_load;
    $fell(core_rst) && cz_q == 2'h0 |-> !watchdog_timeout_flag && !power_down_flag
      && program_counter_low_byte == 8'h00 && low_voltage_level_select_reg == 8'h55;
  endproperty
  a_por_load: assert property (p_por_load) else $error("por state");
  property p_full_reload;
    $fell(core_rst) && cz_q != 2'h3 |-> port_a_data == 8'hFF && int_ctrl == 8'h00
      && stack_pointer_reg == 8'h00;
  endproperty
  a_full_reload: assert property (p_full_reload) else $error("reload");
  property p_rx_clear;
    $fell(core_rst) |-> serial_receive_count_reg == 3'h0;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx count");
  property p_wdt_hold;
    core_rst |=> wdt_clear && timebase_clear && (wdt_run == !core_rst);
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("wdt hold");
  property p_wdt_restart;
    $fell(core_rst) |-> wdt_run ##1 (wdt_run && !wdt_clear && !timebase_clear);
  endproperty
  a_wdt_restart: assert property (p_wdt_restart) else $error("wdt restart");
  property p_hold_len;
    $fell(core_rst) |-> cnt_q == HOLD_CYC && rel;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold length");
endmodule // reset_state_initializer_checker

bind reset_state_initializer reset_state_initializer_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (
  .clk_sys, .srst, .por_req, .lvr_req, .wdt_req, .sleep_mode, .core_rst, .wdt_clear,
  .timebase_clear,
  .wdt_run, .watchdog_timeout_flag, .power_down_flag, .reset_cause_flag_reg,
  .low_voltage_level_select_reg, .program_counter_low_byte, .stack_pointer_reg,
  .serial_receive_count_reg, .port_a_data, .int_ctrl, .pin_sel);

//--- bench/reset_source_model.sv
`timescale 1ns/100ps
module reset_source_model (
  // Clock
  input  wire       clk_sys,
  // Command
  input  wire       go,
  input  wire [1:0] kind,
  input  wire [2:0] len,
  input  wire       sleep,
  // Requests
  output wire       por_req,
  output wire       lvr_req,
  output wire       wdt_req,
  output logic      sleep_mode
);
  logic [1:0] kind_q = 2'h0;
  logic [2:0] left_q = 3'h0;
  initial sleep_mode = 1'b0;
  always @(posedge clk_sys) begin
    sleep_mode <= sleep;
    if (go) begin
      kind_q <= kind;
      left_q <= len;
    end else if (left_q != 3'h0) begin
      left_q <= left_q - 3'h1;
    end
  end
  assign por_req = left_q != 3'h0 && kind_q == 2'h0;
  assign lvr_req = left_q != 3'h0 && kind_q == 2'h1;
  assign wdt_req = left_q != 3'h0 && kind_q[1];
endmodule // reset_source_model

//--- bench/test_reset_state_initializer.sv
`timescale 1ns/100ps
module test_reset_state_initializer;
  logic       clk_sys, srst, go, sleep, reg_wr, reg_rd, acc_ok;
  logic [1:0] kind;
  logic [2:0] len;
  logic [7:0] reg_addr, reg_wdata, d;
  logic [7:0] ex [0:31];
  logic [7:0] wa [0:9] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h18};
  wire        por_req, lvr_req, wdt_req, sleep_mode, core_rst, irq;
  wire  [7:0] reg_rdata;
  int         mismatches, compares, k, seed_v;
  reset_source_model u_src (.clk_sys, .go, .kind, .len, .sleep, .por_req, .lvr_req,
    .wdt_req, .sleep_mode);
  reset_state_initializer #(.HOLD_CYC(2)) u_dut (
    .clk_sys, .srst, .por_req, .lvr_req, .wdt_req, .sleep_mode, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .core_rst, .wdt_clear(), .timebase_clear(), .wdt_run(),
    .watchdog_timeout_flag(), .power_down_flag(), .reset_cause_flag_reg(),
    .watchdog_control_reg(), .software_reset_control_reg(), .low_voltage_level_select_reg(),
    .program_counter_low_byte(), .stack_pointer_reg(), .serial_receive_count_reg(),
    .accumulator_reg(), .port_a_data(), .port_a_dir(), .port_b_data(), .port_b_dir(),
    .port_c_data(), .port_c_dir(), .int_ctrl(), .pin_sel(), .tmr_ctrl(), .irq);
  // ==========================================
  // Tasks
  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == 8'h11) ex[17] &= ~v;
    else ex[a[4:0]] = v;
  endtask
  task automatic check_all;
    for (int a = 0; a < 32; a++) begin
      if (a == 8'h13 || (a == 8'h10 && !acc_ok)) continue;
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= 8'(a);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = (a == 0) ? reg_rdata & 8'h30 : reg_rdata;
      chk(d, ex[a]);
    end
    chk({7'h0, irq}, {7'h0, |(ex[17] & ex[18])});
  endtask
  // Expected state after a reset of the given cause
  task automatic load(input int c);
    logic [7:0] lv;
    lv = ex[4];
    ex[17] |= 8'h01 << c;
    if (c == 3) begin
      ex[0] = 8'h30;
      ex[5] = 8'h00;
      ex[6] &= 8'h80;
      ex[7] = 8'h00;
      ex[15] &= 8'h0F;
    end else begin
      for (int a = 5; a < 30; a++)
        if (a < 16 || a > 18) ex[a] = (a >= 8 && a < 12) ? 8'hFF : 8'h00;
      ex[12] = 8'h3F;
      ex[13] = 8'h3F;
      ex[2] = 8'h53;
      ex[3] = 8'h55;
      ex[4] = (c == 1) ? lv : 8'h55;
      ex[0] = (c == 0) ? 8'h00 : ex[0] | ((c == 2) ? 8'h20 : 8'h00);
      ex[1] = (c == 0) ? 8'h00 : ex[1] | ((c == 1) ? 8'h04 : 8'h00);
    end
  endtask
  task automatic fire(input int c, input logic slp);
    @(posedge clk_sys);
    go    <= 1'b1;
    kind  <= 2'(c);
    len   <= 3'($urandom_range(4, 1));
    sleep <= slp;
    @(posedge clk_sys);
    go <= 1'b0;
    @(negedge clk_sys);
    repeat (8) if (!core_rst) @(negedge clk_sys);
    repeat (16) if (core_rst) @(negedge clk_sys);
    @(posedge clk_sys);
    sleep <= 1'b0;
  endtask
  // ==========================================
  // Stimulus
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {srst, go, kind, len, sleep, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    srst = 1'b1;
    {mismatches, compares, acc_ok} = '0;
    seed_v = $urandom(32'h96F6F15D);
    for (int a = 0; a < 32; a++) ex[a] = 8'h00;
    load(0);
    ex[17] = 8'h00;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    check_all;
    acc_ok = 1'b1;
    for (int i = 0; i < 14; i++) begin
      k = (i < 4) ? (16'h0213 >> (4 * i)) & 3 : $urandom % 4;
      foreach (wa[j]) wr(wa[j], 8'($urandom) & (j == 3 ? 8'h8F : j == 5 ? 8'h3F : 8'hFF));
      wr(8'h12, 8'($urandom) & 8'h0F);
      if ($urandom % 2) wr(8'h11, 8'h0F);
      fire(k, k == 3);
      load(k);
      check_all;
    end
    fire(1, 1'b1);
    #1 chk({7'h0, core_rst}, 8'h00);
    check_all;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    load(0);
    ex[17] = 8'h00;
    ex[18] = 8'h00;
    check_all;
    tally_and_finish;
  end
endmodule // test_reset_state_initializer
